// ==== gpab_defs.svh ====
// register offsets, reset values and pin positions for the three-port gpio block
`ifndef GPAB_DEFS_SVH
`define GPAB_DEFS_SVH
`define GPAB_ADDR_W     4
`define GPAB_PORT_A     2'h0
`define GPAB_PORT_B     2'h1
`define GPAB_PORT_C     2'h2
`define GPAB_FLD_DATA   2'h0
`define GPAB_FLD_PULL   2'h1
`define GPAB_FLD_SLEW   2'h2
`define GPAB_FLD_DIR    2'h3
`define GPAB_RST_BYTE   8'h00
`define GPAB_KBI_CFG    8'hF0
`define GPAB_PC_TXD     0
`define GPAB_PC_RXD     1
`define GPAB_PC_SDA     2
`define GPAB_PC_SCL     3
`endif

// ==== gpab_pkg.sv ====
// shared types of the three-port gpio block
`default_nettype none
package gpab_pkg;
   typedef logic [7:0] gpab_byte_t;
   typedef logic [1:0] gpab_sel_t;
endpackage
`default_nettype wire

// ==== gpab_port_if.sv ====
// settings and read-back of one port between register file and pad control
`timescale 1ns/10ps
`default_nettype none
interface gpab_port_if;
   import gpab_pkg::*;
   gpab_byte_t dat;
   gpab_byte_t pe;
   gpab_byte_t se;
   gpab_byte_t dd;
   gpab_byte_t own;
   gpab_byte_t per_oe;
   gpab_byte_t per_out;
   gpab_byte_t slew_ok;
   gpab_byte_t pull_ok;
   gpab_byte_t pulldn_sel;
   gpab_byte_t read_zero;
   gpab_byte_t rd_val;
   modport ctl (output dat, pe, se, dd, own, per_oe, per_out, slew_ok, pull_ok, pulldn_sel, read_zero,
                input rd_val);
   modport pad (input dat, pe, se, dd, own, per_oe, per_out, slew_ok, pull_ok, pulldn_sel, read_zero,
                output rd_val);
endinterface
`default_nettype wire

// ==== gpab_pad.sv ====
// pad control for one eight-pin port: pin synchroniser, drive, pulls and slew
`timescale 1ns/10ps
`default_nettype none
`include "gpab_defs.svh"
module gpab_pad
   import gpab_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // settings from the register file
   gpab_port_if.pad  cfg,
   // pin side
   input  wire logic [7:0] i_pin,
   output logic      [7:0] o_oe,
   output logic      [7:0] o_out,
   output logic      [7:0] o_pullup,
   output logic      [7:0] o_pulldn,
   output logic      [7:0] o_slew,
   output logic      [7:0] o_level
);
   gpab_byte_t s1_q, s2_q, s3_q;
   gpab_byte_t pull_c, slew_c;

   // three-stage synchroniser, level goes high when the last two are both high, low when either is low
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q    <= `GPAB_RST_BYTE;
         s2_q    <= `GPAB_RST_BYTE;
         s3_q    <= `GPAB_RST_BYTE;
         o_level <= `GPAB_RST_BYTE;
      end else begin
         s1_q    <= i_pin;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         o_level <= (s2_q & s3_q) | (o_level & ~(s2_q ^ s3_q));
      end
   end

   // pulls only on inputs; owned pins obey the owner's pull permission
   assign pull_c = cfg.pe & ~cfg.dd & ((cfg.own & cfg.pull_ok) | ~cfg.own);
   // slew only on driven outputs; owned pins only where the owner allows it
   assign slew_c = cfg.se & ((cfg.own & cfg.slew_ok) | (~cfg.own & cfg.dd));
   // direction bit picks pin level or latch even on owned pins
   assign cfg.rd_val = (cfg.dd & cfg.dat) | (~cfg.dd & ~cfg.read_zero & o_level);

   // registered pad controls; reset leaves undriven inputs without pulls
   always_ff @(posedge clk) begin
      if (rst) begin
         o_oe     <= `GPAB_RST_BYTE;
         o_out    <= `GPAB_RST_BYTE;
         o_pullup <= `GPAB_RST_BYTE;
         o_pulldn <= `GPAB_RST_BYTE;
         o_slew   <= `GPAB_RST_BYTE;
      end else begin
         o_oe     <= (cfg.own & cfg.per_oe) | (~cfg.own & cfg.dd);
         o_out    <= (cfg.own & cfg.per_out) | (~cfg.own & cfg.dat);
         o_pullup <= pull_c & ~cfg.pulldn_sel;
         o_pulldn <= pull_c & cfg.pulldn_sel;
         o_slew   <= slew_c;
      end
   end
endmodule
`default_nettype wire

// ==== gpab_regs.sv ====
// register file and pin ownership for gpio ports a, b and c
// Overview of operation
// - eight pins per port, bit n is pin n
// - data read: pin if input, latch if output
// - data writes always update all eight latches
// - reset clears latch, pins inputs, pulls off
// - direction one drives pin, zero makes input
// - pullup only on input pins
// - slew limit only on output pins
// - rising keyboard pins a7-a4 get pulldown
// - keyboard-owned pin is input, slew ignored
// - keyboard pin pull follows pull bit if input
// - converter-owned b pin ignores dir, slew, pull
// - converter pin with direction zero reads zero
// - serial owns two c pins, slew on transmit
// - pullup on serial receive when direction zero
// - two-wire owns pins, slew clock, driving data
// - pullup on two-wire data while receiving
// - direction still selects read source when overridden
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "gpab_defs.svh"
module gpab_regs
   import gpab_pkg::*;
#(
   parameter int TXD_PIN = `GPAB_PC_TXD,
   parameter int RXD_PIN = `GPAB_PC_RXD,
   parameter int SDA_PIN = `GPAB_PC_SDA,
   parameter int SCL_PIN = `GPAB_PC_SCL
)(
   // clock and reset
   input  wire logic                    I_CORE_CLK,
   input  wire logic                    I_RST,
   // register port
   input  wire logic [`GPAB_ADDR_W-1:0] I_ADDR,
   input  wire logic [7:0]              I_WDATA,
   input  wire logic                    I_WR,
   input  wire logic                    I_RD,
   output logic      [7:0]              O_RDATA,
   // keyboard unit on port a
   input  wire logic [7:0]              I_KBI_EN,
   input  wire logic [7:0]              I_KBI_RISE,
   // analog converter on port b
   input  wire logic [7:0]              I_ADC_EN,
   // serial unit two and two-wire controller on port c
   input  wire logic                    I_SCI_EN,
   input  wire logic                    I_SCI_TXD,
   input  wire logic                    I_IIC_EN,
   input  wire logic                    I_IIC_SDA_OE,
   input  wire logic                    I_IIC_SDA_OUT,
   input  wire logic                    I_IIC_SCL_OE,
   input  wire logic                    I_IIC_SCL_OUT,
   // port a pins
   input  wire logic [7:0]              I_PA_IN,
   output logic      [7:0]              O_PA_OUT,
   output logic      [7:0]              O_PA_OE,
   output logic      [7:0]              O_PA_PULLUP,
   output logic      [7:0]              O_PA_PULLDN,
   output logic      [7:0]              O_PA_SLEW,
   output logic      [7:0]              O_PA_LEVEL,
   // port b pins
   input  wire logic [7:0]              I_PB_IN,
   output logic      [7:0]              O_PB_OUT,
   output logic      [7:0]              O_PB_OE,
   output logic      [7:0]              O_PB_PULLUP,
   output logic      [7:0]              O_PB_PULLDN,
   output logic      [7:0]              O_PB_SLEW,
   output logic      [7:0]              O_PB_LEVEL,
   // port c pins
   input  wire logic [7:0]              I_PC_IN,
   output logic      [7:0]              O_PC_OUT,
   output logic      [7:0]              O_PC_OE,
   output logic      [7:0]              O_PC_PULLUP,
   output logic      [7:0]              O_PC_PULLDN,
   output logic      [7:0]              O_PC_SLEW,
   output logic      [7:0]              O_PC_LEVEL
);
   gpab_byte_t dat_q [3];
   gpab_byte_t pe_q  [3];
   gpab_byte_t se_q  [3];
   gpab_byte_t dd_q  [3];
   gpab_byte_t pin_w [3];
   gpab_byte_t oe_w  [3];
   gpab_byte_t out_w [3];
   gpab_byte_t pu_w  [3];
   gpab_byte_t pd_w  [3];
   gpab_byte_t sl_w  [3];
   gpab_byte_t lv_w  [3];
   gpab_byte_t rd_w  [3];
   gpab_byte_t c_own, c_oe, c_out, c_slew, c_pull;
   gpab_sel_t  port_sel;
   gpab_sel_t  fld_sel;

   gpab_port_if pif [3] ();

   // true when the address names a real port
   function automatic logic port_hit(input gpab_sel_t p);
      port_hit = (p == `GPAB_PORT_A) || (p == `GPAB_PORT_B) || (p == `GPAB_PORT_C);
   endfunction

   assign port_sel = I_ADDR[3:2];
   assign fld_sel  = I_ADDR[1:0];

   // register writes; data latch takes every write whatever the owner
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         for (int p = 0; p < 3; p++) begin
            dat_q[p] <= `GPAB_RST_BYTE;
            pe_q[p]  <= `GPAB_RST_BYTE;
            se_q[p]  <= `GPAB_RST_BYTE;
            dd_q[p]  <= `GPAB_RST_BYTE;
         end
      end else if (I_WR && port_hit(port_sel)) begin
         case (fld_sel)
            `GPAB_FLD_DATA: dat_q[port_sel] <= I_WDATA;
            `GPAB_FLD_PULL: pe_q[port_sel]  <= I_WDATA;
            `GPAB_FLD_SLEW: se_q[port_sel]  <= I_WDATA;
            `GPAB_FLD_DIR:  dd_q[port_sel]  <= I_WDATA;
            default: ;
         endcase
      end
   end

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_RDATA <= `GPAB_RST_BYTE;
      end else if (I_RD && port_hit(port_sel)) begin
         case (fld_sel)
            `GPAB_FLD_DATA: O_RDATA <= rd_w[port_sel];
            `GPAB_FLD_PULL: O_RDATA <= pe_q[port_sel];
            `GPAB_FLD_SLEW: O_RDATA <= se_q[port_sel];
            `GPAB_FLD_DIR:  O_RDATA <= dd_q[port_sel];
            default:        O_RDATA <= `GPAB_RST_BYTE;
         endcase
      end else begin
         O_RDATA <= `GPAB_RST_BYTE;
      end
   end

   // port c ownership by the serial unit and the two-wire controller
   always_comb begin
      c_own  = `GPAB_RST_BYTE;
      c_oe   = `GPAB_RST_BYTE;
      c_out  = `GPAB_RST_BYTE;
      c_slew = `GPAB_RST_BYTE;
      c_pull = `GPAB_RST_BYTE;
      if (I_SCI_EN) begin
         c_own[TXD_PIN]  = 1'b1;
         c_own[RXD_PIN]  = 1'b1;
         c_oe[TXD_PIN]   = 1'b1;
         c_out[TXD_PIN]  = I_SCI_TXD;
         c_slew[TXD_PIN] = 1'b1;
         c_pull[RXD_PIN] = 1'b1;
      end
      if (I_IIC_EN) begin
         c_own[SDA_PIN]  = 1'b1;
         c_own[SCL_PIN]  = 1'b1;
         c_oe[SDA_PIN]   = I_IIC_SDA_OE;
         c_out[SDA_PIN]  = I_IIC_SDA_OUT;
         c_oe[SCL_PIN]   = I_IIC_SCL_OE;
         c_out[SCL_PIN]  = I_IIC_SCL_OUT;
         c_slew[SCL_PIN] = 1'b1;
         c_slew[SDA_PIN] = I_IIC_SDA_OE;
         c_pull[SDA_PIN] = ~I_IIC_SDA_OE;
      end
   end

   // per-port settings and overrides into the pad controls
   generate
      for (genvar p = 0; p < 3; p++) begin : g_port
         assign pif[p].dat = dat_q[p];
         assign pif[p].pe  = pe_q[p];
         assign pif[p].se  = se_q[p];
         assign pif[p].dd  = dd_q[p];
         assign rd_w[p]    = pif[p].rd_val; // interface arrays take constant indices only
      end
   endgenerate

   // port a: keyboard pins are inputs with their own pull choice
   assign pif[0].own        = I_KBI_EN;
   assign pif[0].per_oe     = `GPAB_RST_BYTE;
   assign pif[0].per_out    = `GPAB_RST_BYTE;
   assign pif[0].slew_ok    = `GPAB_RST_BYTE;
   assign pif[0].pull_ok    = I_KBI_EN;
   assign pif[0].pulldn_sel = I_KBI_EN & I_KBI_RISE & `GPAB_KBI_CFG;
   assign pif[0].read_zero  = `GPAB_RST_BYTE;
   // port b: converter pins take no drive, pull or slew
   assign pif[1].own        = I_ADC_EN;
   assign pif[1].per_oe     = `GPAB_RST_BYTE;
   assign pif[1].per_out    = `GPAB_RST_BYTE;
   assign pif[1].slew_ok    = `GPAB_RST_BYTE;
   assign pif[1].pull_ok    = `GPAB_RST_BYTE;
   assign pif[1].pulldn_sel = `GPAB_RST_BYTE;
   assign pif[1].read_zero  = I_ADC_EN;
   // port c: serial and two-wire pins
   assign pif[2].own        = c_own;
   assign pif[2].per_oe     = c_oe;
   assign pif[2].per_out    = c_out;
   assign pif[2].slew_ok    = c_slew;
   assign pif[2].pull_ok    = c_pull;
   assign pif[2].pulldn_sel = `GPAB_RST_BYTE;
   assign pif[2].read_zero  = `GPAB_RST_BYTE;

   assign pin_w[0] = I_PA_IN;
   assign pin_w[1] = I_PB_IN;
   assign pin_w[2] = I_PC_IN;

   // one pad control per port, bit n serving pin n
   generate
      for (genvar p = 0; p < 3; p++) begin : g_pad
         gpab_pad u_pad (
            .clk      (I_CORE_CLK),
            .rst      (I_RST),
            .cfg      (pif[p]),
            .i_pin    (pin_w[p]),
            .o_oe     (oe_w[p]),
            .o_out    (out_w[p]),
            .o_pullup (pu_w[p]),
            .o_pulldn (pd_w[p]),
            .o_slew   (sl_w[p]),
            .o_level  (lv_w[p])
         );
      end
   endgenerate

   // pad flops straight to the pins
   assign O_PA_OE     = oe_w[0];
   assign O_PA_OUT    = out_w[0];
   assign O_PA_PULLUP = pu_w[0];
   assign O_PA_PULLDN = pd_w[0];
   assign O_PA_SLEW   = sl_w[0];
   assign O_PA_LEVEL  = lv_w[0];
   assign O_PB_OE     = oe_w[1];
   assign O_PB_OUT    = out_w[1];
   assign O_PB_PULLUP = pu_w[1];
   assign O_PB_PULLDN = pd_w[1];
   assign O_PB_SLEW   = sl_w[1];
   assign O_PB_LEVEL  = lv_w[1];
   assign O_PC_OE     = oe_w[2];
   assign O_PC_OUT    = out_w[2];
   assign O_PC_PULLUP = pu_w[2];
   assign O_PC_PULLDN = pd_w[2];
   assign O_PC_SLEW   = sl_w[2];
   assign O_PC_LEVEL  = lv_w[2];

   // checks on register and pad behaviour
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   property p_wr_latch;
      (I_WR && I_ADDR == {`GPAB_PORT_A, `GPAB_FLD_DATA}) |=> (dat_q[0] == $past(I_WDATA));
   endproperty
   a_wr_latch: assert property (p_wr_latch) else $error("data write not latched");

   property p_rd_latch;
      (I_RD && I_ADDR == {`GPAB_PORT_A, `GPAB_FLD_DATA} && dd_q[0] == 8'hFF) |=> (O_RDATA == $past(dat_q[0]));
   endproperty
   a_rd_latch: assert property (p_rd_latch) else $error("output pins must read latch");

   property p_rst_pins;
      $fell(I_RST) |-> (O_PA_OE == 8'h00 && O_PB_OE == 8'h00 && O_PC_OE == 8'h00 && O_PA_PULLUP == 8'h00);
   endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("pins not idle after reset");

   property p_dir_drive;
      (dd_q[0][0] && !I_KBI_EN[0]) |=> O_PA_OE[0];
   endproperty
   a_dir_drive: assert property (p_dir_drive) else $error("output pin not driven");

   property p_no_pull_out;
      dd_q[1][1] |=> (!O_PB_PULLUP[1] && !O_PB_PULLDN[1]);
   endproperty
   a_no_pull_out: assert property (p_no_pull_out) else $error("pull on output pin");

   property p_no_slew_in;
      (!dd_q[0][2] && !I_KBI_EN[2]) |=> !O_PA_SLEW[2];
   endproperty
   a_no_slew_in: assert property (p_no_slew_in) else $error("slew on input pin");

   property p_kbi_pulldn;
      (I_KBI_EN[7] && I_KBI_RISE[7] && pe_q[0][7] && !dd_q[0][7]) |=> (O_PA_PULLDN[7] && !O_PA_PULLUP[7]);
   endproperty
   a_kbi_pulldn: assert property (p_kbi_pulldn) else $error("rising key pin lacks pulldown");

   property p_kbi_input;
      I_KBI_EN[3] |=> (!O_PA_OE[3] && !O_PA_SLEW[3]);
   endproperty
   a_kbi_input: assert property (p_kbi_input) else $error("key pin not an input");

   property p_adc_off;
      I_ADC_EN[0] |=> (!O_PB_OE[0] && !O_PB_PULLUP[0] && !O_PB_SLEW[0]);
   endproperty
   a_adc_off: assert property (p_adc_off) else $error("converter pin still controlled");

   property p_adc_zero;
      (I_RD && I_ADDR == {`GPAB_PORT_B, `GPAB_FLD_DATA} && I_ADC_EN == 8'hFF && dd_q[1] == 8'h00)
         |=> (O_RDATA == 8'h00);
   endproperty
   a_adc_zero: assert property (p_adc_zero) else $error("converter pin read not zero");

   property p_sci_tx;
      (I_SCI_EN && !I_RST) |=> (O_PC_OE[TXD_PIN] && O_PC_OUT[TXD_PIN] == $past(I_SCI_TXD));
   endproperty
   a_sci_tx: assert property (p_sci_tx) else $error("transmit pin not driven by serial unit");

   property p_kbi_pull;
      (I_KBI_EN[0] && pe_q[0][0] && !dd_q[0][0]) |=> (O_PA_PULLUP[0] && !O_PA_PULLDN[0]);
   endproperty
   a_kbi_pull: assert property (p_kbi_pull) else $error("key pin pull not set by pull bit");

   property p_sci_rx_pull;
      (I_SCI_EN && pe_q[2][RXD_PIN] && !dd_q[2][RXD_PIN]) |=> O_PC_PULLUP[RXD_PIN];
   endproperty
   a_sci_rx_pull: assert property (p_sci_rx_pull) else $error("receive pin lacks pullup");

   property p_iic_scl;
      (I_IIC_EN && !I_RST) |=> (O_PC_OE[SCL_PIN] == $past(I_IIC_SCL_OE)
         && O_PC_SLEW[SCL_PIN] == $past(se_q[2][SCL_PIN]));
   endproperty
   a_iic_scl: assert property (p_iic_scl) else $error("clock pin not under two-wire control");

   property p_iic_sda_pull;
      (I_IIC_EN && !I_IIC_SDA_OE && pe_q[2][SDA_PIN] && !dd_q[2][SDA_PIN]) |=> O_PC_PULLUP[SDA_PIN];
   endproperty
   a_iic_sda_pull: assert property (p_iic_sda_pull) else $error("receiving data pin lacks pullup");

   property p_owned_read;
      (I_RD && I_ADDR == {`GPAB_PORT_C, `GPAB_FLD_DATA} && I_SCI_EN && dd_q[2] == 8'h00)
         |=> (O_RDATA == $past(O_PC_LEVEL));
   endproperty
   a_owned_read: assert property (p_owned_read) else $error("owned input pin read not pin level");

   property p_gpio_out;
      (!I_KBI_EN[1] && !I_RST) |=> (O_PA_OUT[1] == $past(dat_q[0][1]) && O_PA_OE[1] == $past(dd_q[0][1]));
   endproperty
   a_gpio_out: assert property (p_gpio_out) else $error("free pin not driven from latch");

   c_out_drive: cover property (dd_q[0][0] ##1 O_PA_OE[0]);
   c_owned_rd:  cover property (I_RD && I_SCI_EN && I_ADDR == {`GPAB_PORT_C, `GPAB_FLD_DATA});
   c_kbi_pd:    cover property (O_PA_PULLDN[7]);
   c_iic_own:   cover property (I_IIC_EN && I_IIC_SDA_OE ##1 O_PC_SLEW[SDA_PIN]);
   c_adc_read:  cover property (I_RD && I_ADC_EN != 8'h00);
endmodule
`default_nettype wire

// ==== gpab_pin_model.sv ====
// board and pad model standing outside one eight-pin port
`timescale 1ns/10ps
`default_nettype none
module gpab_pin_model (
   // clock
   input  wire logic       clk,
   // pad controls from the port
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_pullup,
   input  wire logic [7:0] i_pulldn,
   // board drive
   input  wire logic [7:0] i_ext,
   input  wire logic [7:0] i_ext_en,
   // resolved pin level
   output logic      [7:0] o_pin
);
   logic [7:0] float_q = 8'h55;

   // an undriven, unpulled pin wanders every cycle so no stale level hides a fault
   always @(posedge clk) begin
      float_q <= ~float_q;
   end

   // port driver wins, then the board, then the pull devices
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         o_pin[n] = i_oe[n] ? i_out[n] : i_ext_en[n] ? i_ext[n] :
                    i_pullup[n] ? 1'b1 : i_pulldn[n] ? 1'b0 : float_q[n];
      end
   end
endmodule
`default_nettype wire

// ==== gpab_regs_test.sv ====
// self-checking bench for the three-port gpio register block
`timescale 1ns/10ps
`default_nettype none
`include "gpab_defs.svh"
module gpab_regs_test;
   import gpab_pkg::*;
   typedef struct packed {
      gpab_sel_t  p;
      gpab_byte_t dd, pe, se, dat;
   } gpab_row_t;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] addr = 4'h0;
   gpab_byte_t wdata = 8'h00;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   gpab_byte_t rdata;
   gpab_byte_t kbi_en = 8'h00;
   gpab_byte_t kbi_rise = 8'h00;
   gpab_byte_t adc_en = 8'h00;
   logic       sci_en = 1'b0;
   logic       sci_txd = 1'b0;
   logic       iic_en = 1'b0;
   logic [3:0] two_wire_controller = 4'h0; // sda oe, sda out, scl oe, scl out
   gpab_byte_t ext_en [3] = '{8'hFF, 8'hFF, 8'hFF};
   gpab_byte_t pin [3];
   gpab_byte_t oe [3];
   gpab_byte_t out [3];
   gpab_byte_t pu [3];
   gpab_byte_t pd [3];
   gpab_byte_t sl [3];
   gpab_byte_t lvl [3];
   int         fail_count = 0;
   int         tests_run = 0;
   gpab_row_t  rows [4] = '{'{2'h0, 8'h0F, 8'hFF, 8'hFF, 8'h3C}, '{2'h1, 8'hFF, 8'hFF, 8'h00, 8'h81},
                            '{2'h2, 8'h00, 8'h5A, 8'hFF, 8'hFF}, '{2'h0, 8'hAA, 8'h55, 8'hF0, 8'h00}};

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   gpab_regs DUT (
      .I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
      .O_RDATA(rdata), .I_KBI_EN(kbi_en), .I_KBI_RISE(kbi_rise), .I_ADC_EN(adc_en),
      .I_SCI_EN(sci_en), .I_SCI_TXD(sci_txd), .I_IIC_EN(iic_en), .I_IIC_SDA_OE(two_wire_controller[3]),
      .I_IIC_SDA_OUT(two_wire_controller[2]), .I_IIC_SCL_OE(two_wire_controller[1]), .I_IIC_SCL_OUT(two_wire_controller[0]),
      .I_PA_IN(pin[0]), .O_PA_OUT(out[0]), .O_PA_OE(oe[0]), .O_PA_PULLUP(pu[0]), .O_PA_PULLDN(pd[0]),
      .O_PA_SLEW(sl[0]), .O_PA_LEVEL(lvl[0]),
      .I_PB_IN(pin[1]), .O_PB_OUT(out[1]), .O_PB_OE(oe[1]), .O_PB_PULLUP(pu[1]), .O_PB_PULLDN(pd[1]),
      .O_PB_SLEW(sl[1]), .O_PB_LEVEL(lvl[1]),
      .I_PC_IN(pin[2]), .O_PC_OUT(out[2]), .O_PC_OE(oe[2]), .O_PC_PULLUP(pu[2]), .O_PC_PULLDN(pd[2]),
      .O_PC_SLEW(sl[2]), .O_PC_LEVEL(lvl[2]));

   // one pin model per port, board drive A5 where enabled
   for (genvar g = 0; g < 3; g++) begin : g_pin
      gpab_pin_model u_pin (.clk(clk), .i_oe(oe[g]), .i_out(out[g]), .i_pullup(pu[g]), .i_pulldn(pd[g]),
                            .i_ext(8'hA5), .i_ext_en(ext_en[g]), .o_pin(pin[g]));
   end

   // compare and count
   task automatic chk(input gpab_byte_t seen, input gpab_byte_t exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input gpab_byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic rdc(input logic [3:0] a, input gpab_byte_t e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // data first, then pull, slew and direction; wait for the pads
   task automatic setp(input gpab_sel_t p, input gpab_byte_t dd, pe, se, dat);
      wr({p, `GPAB_FLD_DATA}, dat);
      wr({p, `GPAB_FLD_PULL}, pe);
      wr({p, `GPAB_FLD_SLEW}, se);
      wr({p, `GPAB_FLD_DIR}, dd);
      repeat (2) @(posedge clk);
      #1;
   endtask

   // pad outputs of one port; output value only matters where driven
   task automatic chkp(input int p, input gpab_byte_t eoe, eout, epu, epd, esl);
      chk(oe[p], eoe);
      chk(out[p] & oe[p], eout & eoe);
      chk(pu[p], epu);
      chk(pd[p], epd);
      chk(sl[p], esl);
   endtask

   task automatic results;
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog: the run needs well under a thousand cycles
   initial begin
      #20000;
      fail_count++;
      results();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      #1;
      for (int p = 0; p < 3; p++) chkp(p, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      @(posedge clk);
      rst <= 1'b0;
      // let the synchronisers take the board value before reading data fields
      repeat (4) @(posedge clk);
      for (int a = 0; a < 12; a++) rdc(a[3:0], (a[1:0] == 2'h0) ? 8'hA5 : 8'h00);
      // ordinary gpio settings, inputs see the board value
      foreach (rows[i]) begin
         setp(rows[i].p, rows[i].dd, rows[i].pe, rows[i].se, rows[i].dat);
         chkp(rows[i].p, rows[i].dd, rows[i].dat, rows[i].pe & ~rows[i].dd, 8'h00, rows[i].se & rows[i].dd);
         repeat (4) @(posedge clk);
         #1;
         chk(lvl[rows[i].p], (rows[i].dat & rows[i].dd) | (8'hA5 & ~rows[i].dd));
         rdc({rows[i].p, `GPAB_FLD_DATA}, (rows[i].dat & rows[i].dd) | (8'hA5 & ~rows[i].dd));
         rdc({rows[i].p, `GPAB_FLD_PULL}, rows[i].pe);
         rdc({rows[i].p, `GPAB_FLD_SLEW}, rows[i].se);
         rdc({rows[i].p, `GPAB_FLD_DIR}, rows[i].dd);
      end
      // keyboard unit owns port a, upper half detects rising edges
      @(posedge clk);
      kbi_en <= 8'hFF;
      kbi_rise <= 8'hF0;
      ext_en[0] <= 8'h00;
      setp(2'h0, 8'h00, 8'hFF, 8'hFF, 8'hC3);
      chkp(0, 8'h00, 8'h00, 8'h0F, 8'hF0, 8'h00);
      repeat (6) @(posedge clk);
      #1;
      chk(lvl[0], 8'h0F);
      rdc(4'h0, 8'h0F);
      wr(4'h3, 8'hFF);
      repeat (2) @(posedge clk);
      #1;
      chkp(0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      rdc(4'h0, 8'hC3);
      @(posedge clk);
      kbi_en <= 8'h00;
      ext_en[0] <= 8'hFF;
      repeat (2) @(posedge clk);
      #1;
      chkp(0, 8'hFF, 8'hC3, 8'h00, 8'h00, 8'hFF);
      // unmapped port: writes vanish, reads give zero
      wr(4'hC, 8'hFF);
      rdc(4'hC, 8'h00);
      rdc(4'hF, 8'h00);
      rdc(4'h0, 8'hC3);
      // converter owns port b
      @(posedge clk);
      adc_en <= 8'hFF;
      setp(2'h1, 8'h0F, 8'hFF, 8'hFF, 8'h5A);
      chkp(1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      rdc(4'h4, 8'h0A);
      // serial unit and two-wire controller own port c, data line receiving
      @(posedge clk);
      sci_en <= 1'b1;
      sci_txd <= 1'b1;
      iic_en <= 1'b1;
      two_wire_controller <= 4'b0010;
      setp(2'h2, 8'h00, 8'hFF, 8'hFF, 8'h00);
      chkp(2, 8'h09, 8'h01, 8'hF6, 8'h00, 8'h09);
      // data line now driving high
      @(posedge clk);
      two_wire_controller <= 4'b1110;
      repeat (2) @(posedge clk);
      #1;
      chkp(2, 8'h0D, 8'h05, 8'hF2, 8'h00, 8'h0D);
      // owned pins still read back the pin level while direction is zero
      repeat (4) @(posedge clk);
      #1;
      chk(lvl[2], 8'hA5);
      rdc(4'h8, 8'hA5);
      // second reset in mid-run with peripherals still enabled
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      for (int p = 0; p < 3; p++) chkp(p, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      @(posedge clk);
      rst <= 1'b0;
      rdc(4'h3, 8'h00);
      wr(4'h3, 8'hFF);
      rdc(4'h0, 8'h00);
      results();
   end
endmodule
`default_nettype wire
